/* File: rtl/tcs_pkg.sv */
// package for the tape controller command and status block
package tcs_pkg;
  // command codes issued by the host channel
  localparam logic [3:0] CMD_RESERVED = 4'h0;
  localparam logic [3:0] CMD_SELECT = 4'h1;
  localparam logic [3:0] CMD_WRITE_REC = 4'h2;
  localparam logic [3:0] CMD_READ_REC = 4'h3;
  localparam logic [3:0] CMD_FWD_REC = 4'h4;
  localparam logic [3:0] CMD_FWD_FILE = 4'h5;
  localparam logic [3:0] CMD_BACK_REC = 4'h6;
  localparam logic [3:0] CMD_BACK_FILE = 4'h7;
  localparam logic [3:0] CMD_REWIND = 4'h8;
  localparam logic [3:0] CMD_WRITE_GAP = 4'h9;
  localparam logic [3:0] CMD_WRITE_FM = 4'hA;
  localparam logic [3:0] CMD_CLEAR = 4'hB;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STAT1 = 8'h04;
  localparam logic [7:0] ADDR_STAT2 = 8'h08;
  localparam logic [7:0] ADDR_JUMP = 8'h0C;
  localparam logic [7:0] ADDR_BURST = 8'h10;
  localparam logic [7:0] ADDR_DATA = 8'h14;

  // command register fields
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_UNIT_LSB = 4;
  localparam int CMD_NOWAIT_BIT = 8;
  // burst length register value out of reset
  localparam logic [15:0] BURST_RESET = 16'h0040;

  // status byte 1 bit positions
  localparam int S1_FILE_MARK = 0;
  localparam int S1_LOAD_POINT = 1;
  localparam int S1_END_OF_TAPE = 2;
  localparam int S1_SINGLE_TRACK = 3;
  localparam int S1_REJECT = 4;
  localparam int S1_MULTI_TRACK = 6;
  // status byte 2 bit positions
  localparam int S2_TIMING = 3;
  localparam int S2_RUNAWAY = 4;
  localparam int S2_REWINDING = 5;
  localparam int S2_UNIT_BUSY = 6;
  localparam int S2_IF_BUSY = 7;
  localparam int S2_UNIT_LSB = 9;

  // completion-jump codes
  localparam logic [1:0] JUMP_DONE = 2'h0;
  localparam logic [1:0] JUMP_ERROR = 2'h1;
  localparam logic [1:0] JUMP_MORE = 2'h2;

  // timing: backspace-file deadline and host data window
  localparam int CLK_MHZ = 250;
  localparam int BSF_LIMIT_MS = 85;
  localparam int BSF_LIMIT_CYC = BSF_LIMIT_MS * 1000 * CLK_MHZ;
  localparam int DATA_WINDOW_NS = 400;
  localparam int DATA_WINDOW_CYC = DATA_WINDOW_NS * CLK_MHZ / 1000;

  // transport event strobes from the tape unit
  typedef struct packed {
    logic motion_done;
    logic file_mark;
    logic blank;
    logic end_of_tape_flag;
    logic load_point;
    logic single_track;
    logic multi_track;
    logic record_end;
    logic bad_record;
  } tcs_tape_s;

  // motion request to the transport
  typedef struct packed {
    logic start;
    logic [3:0] op;
    logic [1:0] unit;
  } tcs_motion_s;
endpackage : tcs_pkg

/* File: rtl/tcs_top.sv */
// command interpreter and status bytes of a tape controller
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Operation
// - echo selected unit in status byte two
// - code zero rejected, flag set
// - no-wait rewind shows rewinding, unit busy
// - unit busy clears when rewind finishes
// - early-ended read leaves file mark clear
// - reads move in host-chosen bursts
// - incomplete-written record reads nonzero jump
// - end-of-tape during gaps sets flag
// - one more gap past marker allowed
// - spacing or reading blank tape: runaway
// - slow host write data: timing error
// - track fault flags clear after good read
// - load point clear after short backspace
// - backspace file ends within deadline
// - overwritten record tail reads nonzero jump
// - file mark flag when motion crossed one
module tcs_top #(
  parameter int BSF_LIMIT = tcs_pkg::BSF_LIMIT_CYC
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // tape transport
  input wire tcs_pkg::tcs_tape_s tape_evt,
  output tcs_pkg::tcs_motion_s motion_q,
  output logic word_strobe_q,
  output logic [15:0] write_word_q
);

  typedef enum logic [2:0] {
    TCS_IDLE = 3'b000,
    TCS_MOVE = 3'b001,
    TCS_XFER = 3'b011,
    TCS_WAIT = 3'b010,
    TCS_DONE = 3'b110
  } tcs_state_e;

  tcs_state_e state_q;
  logic [7:0] stat1_q;
  logic [15:0] stat2_q;
  logic [1:0] jump_q;
  logic [1:0] unit_q;
  logic [3:0] op_q;
  logic nowait_q;
  logic rewinding_q;
  logic eot_seen_q;
  logic [15:0] burst_q;
  logic [15:0] burst_cnt_q;
  logic [31:0] timer_q;
  logic data_ready_q;
  logic timing_q;

  // bus decode; every access answers in its first access cycle
  logic wr_en;
  logic rd_en;
  logic [3:0] code;
  logic busy;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign code = pwdata[tcs_pkg::CMD_CODE_LSB +: 4];
  assign busy = (state_q != TCS_IDLE) && (state_q != TCS_DONE);

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == tcs_pkg::ADDR_CMD) || (a == tcs_pkg::ADDR_STAT1) ||
                (a == tcs_pkg::ADDR_STAT2) || (a == tcs_pkg::ADDR_JUMP) ||
                (a == tcs_pkg::ADDR_BURST) || (a == tcs_pkg::ADDR_DATA);
  endfunction : is_mapped

  logic cmd_wr;
  logic data_wr;
  assign cmd_wr = wr_en && (paddr == tcs_pkg::ADDR_CMD);
  assign data_wr = wr_en && (paddr == tcs_pkg::ADDR_DATA);

  // ready and error flags registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~is_mapped(paddr);
    end
  end

  // read data captured in setup so the answer comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        tcs_pkg::ADDR_STAT1: prdata <= {24'h00_0000, stat1_q};
        tcs_pkg::ADDR_STAT2: prdata <= {16'h0000, stat2_q};
        tcs_pkg::ADDR_JUMP: prdata <= {30'h0000_0000, jump_q};
        tcs_pkg::ADDR_BURST: prdata <= {16'h0000, burst_q};
        tcs_pkg::ADDR_CMD: prdata <= {28'h000_0000, op_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // burst length chosen by the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_q <= tcs_pkg::BURST_RESET;
    end else if (wr_en && (paddr == tcs_pkg::ADDR_BURST)) begin
      burst_q <= pwdata[15:0];
    end
  end

  // command state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= TCS_IDLE;
      op_q <= tcs_pkg::CMD_RESERVED;
      nowait_q <= 1'b0;
    end else if (cmd_wr && (code == tcs_pkg::CMD_CLEAR)) begin
      state_q <= TCS_IDLE;
      op_q <= tcs_pkg::CMD_CLEAR;
    end else begin
      case (state_q)
        TCS_IDLE, TCS_DONE: begin
          if (cmd_wr && code != tcs_pkg::CMD_RESERVED && code != tcs_pkg::CMD_SELECT) begin
            op_q <= code;
            nowait_q <= pwdata[tcs_pkg::CMD_NOWAIT_BIT];
            // no-wait rewind never shows interface busy
            if (code == tcs_pkg::CMD_REWIND && pwdata[tcs_pkg::CMD_NOWAIT_BIT]) begin
              state_q <= TCS_DONE;
            end else begin
              state_q <= (code == tcs_pkg::CMD_READ_REC || code == tcs_pkg::CMD_WRITE_REC)
                         ? TCS_XFER : TCS_MOVE;
            end
          end else if (cmd_wr) begin
            op_q <= code;
            state_q <= TCS_DONE;
          end
        end
        TCS_MOVE: begin
          // no-wait rewind frees the interface at once
          if (op_q == tcs_pkg::CMD_REWIND && nowait_q) begin
            state_q <= TCS_DONE;
          end else if (tape_evt.motion_done || tape_evt.blank ||
                       timer_q == BSF_LIMIT[31:0]) begin
            state_q <= TCS_DONE;
          end
        end
        TCS_XFER: begin
          if (tape_evt.record_end || tape_evt.blank || tape_evt.bad_record) begin
            state_q <= TCS_DONE;
          end else if (burst_cnt_q == burst_q && burst_q != 16'h0000) begin
            state_q <= TCS_WAIT;
          end
        end
        TCS_WAIT: begin
          if (data_wr) begin
            state_q <= TCS_XFER;
          end
        end
        default: state_q <= TCS_IDLE;
      endcase
    end
  end

  // words counted inside a burst; host data write restarts the burst
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_cnt_q <= 16'h0000;
    end else if (state_q != TCS_XFER || data_wr) begin
      burst_cnt_q <= data_wr ? 16'h0001 : 16'h0000;
    end else if (tape_evt.motion_done) begin
      burst_cnt_q <= burst_cnt_q + 16'h0001;
    end
  end

  // motion timer for the backspace-file deadline and data window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_q <= 32'h0000_0000;
    end else if (state_q == TCS_IDLE || state_q == TCS_DONE || data_wr) begin
      timer_q <= 32'h0000_0000;
    end else begin
      timer_q <= timer_q + 32'h0000_0001;
    end
  end

  // write data late beyond the window
  assign timing_q = (state_q == TCS_XFER) && (op_q == tcs_pkg::CMD_WRITE_REC) &&
                    (timer_q == 32'(tcs_pkg::DATA_WINDOW_CYC));

  // unit select and motion request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_q <= 2'h0;
      motion_q <= '0;
    end else begin
      if (cmd_wr && code == tcs_pkg::CMD_SELECT && !busy) begin
        unit_q <= pwdata[tcs_pkg::CMD_UNIT_LSB +: 2];
      end
      motion_q.start <= cmd_wr && !busy && code != tcs_pkg::CMD_RESERVED &&
                        code != tcs_pkg::CMD_SELECT && code != tcs_pkg::CMD_CLEAR;
      motion_q.op <= code;
      motion_q.unit <= unit_q;
    end
  end

  // host write words to the transport
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_strobe_q <= 1'b0;
      write_word_q <= 16'h0000;
    end else begin
      word_strobe_q <= data_wr && op_q == tcs_pkg::CMD_WRITE_REC;
      if (data_wr) begin
        write_word_q <= pwdata[15:0];
      end
    end
  end

  // rewind tracking; busy drops when motion ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rewinding_q <= 1'b0;
    end else if (cmd_wr && code == tcs_pkg::CMD_REWIND && !busy) begin
      rewinding_q <= 1'b1;
    end else if (tape_evt.motion_done || tape_evt.load_point ||
                 (cmd_wr && code == tcs_pkg::CMD_CLEAR)) begin
      rewinding_q <= 1'b0;
    end
  end

  // status byte 1; cleared only when a new command starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat1_q <= 8'h00;
      eot_seen_q <= 1'b0;
    end else if (cmd_wr && !busy) begin
      stat1_q <= 8'h00;
      stat1_q[tcs_pkg::S1_REJECT] <= (code == tcs_pkg::CMD_RESERVED);
      stat1_q[tcs_pkg::S1_END_OF_TAPE] <= eot_seen_q && code != tcs_pkg::CMD_REWIND;
      stat1_q[tcs_pkg::S1_LOAD_POINT] <= stat1_q[tcs_pkg::S1_LOAD_POINT] &&
                                         code == tcs_pkg::CMD_SELECT;
    end else begin
      if (tape_evt.file_mark && busy) begin
        stat1_q[tcs_pkg::S1_FILE_MARK] <= 1'b1;
      end
      if (tape_evt.end_of_tape_flag) begin
        stat1_q[tcs_pkg::S1_END_OF_TAPE] <= 1'b1;
        eot_seen_q <= 1'b1;
      end
      if (tape_evt.load_point) begin
        stat1_q[tcs_pkg::S1_LOAD_POINT] <= 1'b1;
        eot_seen_q <= 1'b0;
      end
      // track faults only on reported errors
      if (tape_evt.single_track) begin
        stat1_q[tcs_pkg::S1_SINGLE_TRACK] <= 1'b1;
      end
      if (tape_evt.multi_track) begin
        stat1_q[tcs_pkg::S1_MULTI_TRACK] <= 1'b1;
      end
    end
  end

  // status byte 2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat2_q <= 16'h0000;
    end else begin
      stat2_q[tcs_pkg::S2_UNIT_LSB +: 2] <= unit_q;
      stat2_q[tcs_pkg::S2_REWINDING] <= rewinding_q;
      stat2_q[tcs_pkg::S2_UNIT_BUSY] <= rewinding_q || busy;
      stat2_q[tcs_pkg::S2_IF_BUSY] <= busy;
      if (cmd_wr && !busy) begin
        stat2_q[tcs_pkg::S2_RUNAWAY] <= 1'b0;
        stat2_q[tcs_pkg::S2_TIMING] <= 1'b0;
      end else begin
        if (tape_evt.blank && busy) begin
          stat2_q[tcs_pkg::S2_RUNAWAY] <= 1'b1;
        end
        if (timing_q) begin
          stat2_q[tcs_pkg::S2_TIMING] <= 1'b1;
        end
      end
    end
  end

  // completion-jump code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jump_q <= tcs_pkg::JUMP_DONE;
    end else if (cmd_wr && !busy) begin
      jump_q <= tcs_pkg::JUMP_DONE;
    end else if (state_q == TCS_XFER && burst_cnt_q == burst_q && burst_q != 16'h0000) begin
      jump_q <= tcs_pkg::JUMP_MORE;
    end else if (data_wr && state_q == TCS_WAIT) begin
      jump_q <= tcs_pkg::JUMP_DONE;
    end else if (tape_evt.bad_record || tape_evt.blank || timing_q ||
                 (state_q == TCS_MOVE && timer_q == BSF_LIMIT[31:0])) begin
      jump_q <= tcs_pkg::JUMP_ERROR;
    end
  end
endmodule : tcs_top

/* File: tb/tb_tape_controller_status.sv */
// self-checking bench for the tape controller command and status block
`timescale 1ns/1ps
`define TCS_CMP(got, want) \
  begin \
    check_count++; \
    if ((got) !== (want)) begin \
      errors++; \
      $display("Error at %0t ns: got %h expected %h", $time, got, want); \
    end \
  end
module tb_tape_controller_status;
  typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} tcs_note_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  tcs_pkg::tcs_tape_s tape_evt;
  tcs_pkg::tcs_motion_s motion_q;
  tcs_pkg::tcs_tape_s flags = '0;
  logic [7:0] delay = 8'h02;
  logic [7:0] nwords = 8'h01;
  logic word_strobe_q;
  logic [15:0] write_word_q;
  logic [3:0] run_ops [3] = '{4'h5, 4'h4, 4'h3};
  tcs_note_s notes [$];
  tcs_note_s note;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;

  always #2 pclk = ~pclk;

  tcs_top #(.BSF_LIMIT(200)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tape_evt(tape_evt), .motion_q(motion_q), .word_strobe_q(word_strobe_q),
    .write_word_q(write_word_q)
  );
  tcs_tape_model i_tape (
    .pclk(pclk), .presetn(presetn), .motion(motion_q), .flags(flags), .delay(delay),
    .nwords(nwords), .tape_evt(tape_evt)
  );

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // one apb transfer; an idle edge follows so strobes are never reassigned at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic er);
    notes.push_back('{e, m, er});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic cmd(input logic [31:0] c);
    apb(1'b1, tcs_pkg::ADDR_CMD, c);
  endtask : cmd

  task automatic mwait(input int n);
    repeat (n) @(posedge tape_evt.motion_done);
    repeat (3) @(posedge pclk);
  endtask : mwait

  // each completed read retires the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
      note = notes.pop_front();
      `TCS_CMP({pslverr, prdata & note.mask}, {note.err, note.exp})
    end
  end

  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    void'($urandom(23));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(tcs_pkg::ADDR_BURST, 32'hFFFFFFFF, 32'h00000040, 1'b0);
    rd(8'h18, 32'h0, 32'h0, 1'b1);
    $display("test reset done");
    for (int u = 0; u < 4; u++) begin
      cmd({26'h0, u[1:0], tcs_pkg::CMD_SELECT});
      rd(tcs_pkg::ADDR_STAT2, 32'h600, {21'h0, u[1:0], 9'h0}, 1'b0);
    end
    cmd(32'h0);
    rd(tcs_pkg::ADDR_STAT1, 32'h10, 32'h10, 1'b0);
    // slow rewind without waiting
    delay <= 8'h28;
    cmd(32'h108);
    rd(tcs_pkg::ADDR_STAT2, 32'hE0, 32'h60, 1'b0);
    mwait(1);
    rd(tcs_pkg::ADDR_STAT2, 32'h40, 32'h0, 1'b0);
    delay <= 8'h02;
    $display("test select reject rewind done");
    flags <= 9'h040;
    foreach (run_ops[i]) begin
      cmd({28'h0, run_ops[i]});
      mwait(1);
      rd(tcs_pkg::ADDR_STAT2, 32'h10, 32'h10, 1'b0);
    end
    flags <= 9'h020;
    // second gap has no marker strobe, so the flag must be carried over
    repeat (2) begin
      cmd({28'h0, tcs_pkg::CMD_WRITE_GAP});
      mwait(1);
      rd(tcs_pkg::ADDR_STAT1, 32'h4, 32'h4, 1'b0);
      flags <= '0;
    end
    flags <= 9'h080;
    cmd({28'h0, tcs_pkg::CMD_FWD_REC});
    mwait(1);
    rd(tcs_pkg::ADDR_STAT1, 32'h49, 32'h1, 1'b0);
    cmd({28'h0, tcs_pkg::CMD_BACK_FILE});
    mwait(1);
    rd(tcs_pkg::ADDR_STAT1, 32'h3, 32'h1, 1'b0);
    rd(tcs_pkg::ADDR_JUMP, 32'h3, {30'h0, tcs_pkg::JUMP_DONE}, 1'b0);
    // transport slower than the deadline must end with a fault code
    delay <= 8'hFF;
    cmd({28'h0, tcs_pkg::CMD_BACK_FILE});
    mwait(1);
    rd(tcs_pkg::ADDR_JUMP, 32'h3, {30'h0, tcs_pkg::JUMP_ERROR}, 1'b0);
    delay <= 8'h02;
    flags <= 9'h003;
    cmd({28'h0, tcs_pkg::CMD_READ_REC});
    mwait(1);
    rd(tcs_pkg::ADDR_JUMP, 32'h3, {30'h0, tcs_pkg::JUMP_ERROR}, 1'b0);
    $display("test tape flags done");
    // write with the host far too slow between words
    flags <= '0;
    nwords <= 8'h00;
    cmd({28'h0, tcs_pkg::CMD_WRITE_REC});
    repeat (2) begin
      apb(1'b1, tcs_pkg::ADDR_DATA, {16'h0, 16'($urandom)});
      repeat (150) @(posedge pclk);
    end
    rd(tcs_pkg::ADDR_STAT2, 32'h8, 32'h8, 1'b0);
    cmd({28'h0, tcs_pkg::CMD_CLEAR});
    // burst of 60 then early end
    apb(1'b1, tcs_pkg::ADDR_BURST, 32'h3C);
    rd(tcs_pkg::ADDR_BURST, 32'hFFFFFFFF, 32'h3C, 1'b0);
    nwords <= 8'h3C;
    cmd({28'h0, tcs_pkg::CMD_READ_REC});
    mwait(60);
    rd(tcs_pkg::ADDR_JUMP, 32'h3, {30'h0, tcs_pkg::JUMP_MORE}, 1'b0);
    nwords <= 8'h01;
    cmd({28'h0, tcs_pkg::CMD_CLEAR});
    rd(tcs_pkg::ADDR_STAT1, 32'h1, 32'h0, 1'b0);
    cmd(32'h31);
    rd(tcs_pkg::ADDR_STAT2, 32'h600, 32'h600, 1'b0);
    $display("test write burst clear done");
    final_report();
  end
endmodule : tb_tape_controller_status

bind tcs_top tcs_sva #(.BSF_LIMIT(BSF_LIMIT)) i_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tape_evt(tape_evt), .motion_q(motion_q), .word_strobe_q(word_strobe_q),
  .write_word_q(write_word_q)
);

/* File: tb/tcs_sva.sv */
// port assertions for the tape controller command and status block
`timescale 1ns/1ps
module tcs_sva #(
  parameter int BSF_LIMIT = 200
) (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // transport side
  input wire tcs_pkg::tcs_tape_s tape_evt,
  input wire tcs_pkg::tcs_motion_s motion_q,
  input wire logic word_strobe_q,
  input wire logic [15:0] write_word_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic cmd_wr;
  // completed access and command write
  assign acc = psel && penable && pready;
  assign cmd_wr = acc && pwrite && paddr == tcs_pkg::ADDR_CMD;

  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
  property p_rdy_when; pready |-> psel && penable && $past(psel && !penable); endproperty
  a_rdy_when: assert property (p_rdy_when) else $error("pready outside first access cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_unmap; acc && paddr > 8'h14 |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_reject; cmd_wr && pwdata[3:0] == 4'h0 |=> !motion_q.start; endproperty
  a_reject: assert property (p_reject) else $error("reserved code moved tape");
  property p_start_cause; motion_q.start |-> $past(acc && pwrite); endproperty
  a_start_cause: assert property (p_start_cause) else $error("motion without a write");
  property p_start_pulse; motion_q.start |=> !motion_q.start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("motion start held");
  property p_start_op; motion_q.start |-> motion_q.op == $past(pwdata[3:0]); endproperty
  a_start_op: assert property (p_start_op) else $error("motion op differs from command");
  // the word handed on must be the one the host just wrote
  property p_word;
    word_strobe_q |-> $past(acc && pwrite && paddr == tcs_pkg::ADDR_DATA)
      && write_word_q == $past(pwdata[15:0]);
  endproperty
  a_word: assert property (p_word) else $error("word strobe wrong");
  property p_hold; !(psel && !penable) |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  c_reject: cover property (cmd_wr && pwdata[3:0] == 4'h0);
  c_word: cover property (word_strobe_q);
  c_err: cover property (pslverr);
endmodule : tcs_sva

/* File: tb/tcs_tape_model.sv */
// behavioural tape transport answering motion requests
`timescale 1ns/1ps
module tcs_tape_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request and scripted reply
  input wire tcs_pkg::tcs_motion_s motion,
  input wire tcs_pkg::tcs_tape_s flags,
  input wire logic [7:0] delay,
  input wire logic [7:0] nwords,
  // strobes back
  output tcs_pkg::tcs_tape_s tape_evt
);
  logic [7:0] wait_q;
  logic [7:0] left_q;
  // one strobe per word
  // flags ride on the last strobe only, so early words stay clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 8'h00;
      left_q <= 8'h00;
      tape_evt <= '0;
    end else begin
      tape_evt <= '0;
      if (motion.start) begin
        wait_q <= delay;
        left_q <= nwords;
      end else if (left_q != 8'h00 && wait_q != 8'h00) begin
        wait_q <= wait_q - 8'h01;
      end else if (left_q != 8'h00) begin
        wait_q <= delay;
        left_q <= left_q - 8'h01;
        if (left_q == 8'h01)
          tape_evt <= flags;
        tape_evt.motion_done <= 1'b1;
      end
    end
  end
endmodule : tcs_tape_model
